// ### shared/rx_slice_pkg.sv
package rx_slice_pkg;
  localparam int TAP_WIDTH = 9;
  localparam int WORD_WIDTH = 8;
  localparam int QUEUE_DEPTH = 2;
  localparam int PTR_WIDTH = 2;
  localparam int BIT_COUNT_WIDTH = 3;
  localparam logic [TAP_WIDTH-1:0] TAP_RESET = 9'h000;
  localparam logic [TAP_WIDTH-1:0] TAP_ONE = 9'h001;
  localparam logic [WORD_WIDTH-1:0] WORD_RESET = 8'h00;
  localparam logic [PTR_WIDTH-1:0] PTR_RESET = 2'h0;
  localparam logic [BIT_COUNT_WIDTH-1:0] BIT_COUNT_RESET = 3'h0;
  // Bit counter value that closes a word, and the one that raises the write clock
  localparam logic [BIT_COUNT_WIDTH-1:0] BIT_COUNT_LAST = 3'h7;
  localparam logic [BIT_COUNT_WIDTH-1:0] BIT_COUNT_HALF = 3'h3;
endpackage

// ### tb/fabric_model.sv
`timescale 1ns/100ps
module fabric_model (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic queueEmpty,
  input wire logic stall,
  output logic readEnable
);
  // Registered inverted empty; one stale read may hit an empty queue and is refused
  always_ff @(posedge clk) begin
    readEnable <= !sys_rst && !stall && !queueEmpty;
  end
endmodule

// ### tb/tb_rx_slice_tap_fifo.sv
`timescale 1ns/100ps
module tb_rx_slice_tap_fifo;
  import rx_slice_pkg::*;
  logic clk, sys_rst, serialDataPin, driftCompEnable, tapLoad, isStrobeSlice, isNibbleBase;
  logic ctrlStepInc, ctrlStepDec, stall, readEnable, driftCompActive, readValid, queueEmpty;
  logic captureReady, captureOverflow, queueWriteClockOut, dataOn;
  logic [TAP_WIDTH-1:0] tapValueIn, tapValueOut, cur;
  logic [WORD_WIDTH-1:0] readData, pat;
  int err_count = 0, total_checks = 0, seed = 32'h9f7d, v, e, w, edgeNum = 0;
  rx_slice_tap_fifo i_dut (.clk(clk), .sys_rst(sys_rst), .serialDataPin(serialDataPin),
    .driftCompEnable(driftCompEnable), .tapValueIn(tapValueIn), .tapLoad(tapLoad),
    .isStrobeSlice(isStrobeSlice), .isNibbleBase(isNibbleBase), .ctrlStepInc(ctrlStepInc),
    .ctrlStepDec(ctrlStepDec), .readEnable(readEnable), .tapValueOut(tapValueOut),
    .driftCompActive(driftCompActive), .readData(readData), .readValid(readValid),
    .queueEmpty(queueEmpty), .captureReady(captureReady), .captureOverflow(captureOverflow),
    .queueWriteClockOut(queueWriteClockOut));
  fabric_model i_fabric (.clk(clk), .sys_rst(sys_rst), .queueEmpty(queueEmpty), .stall(stall),
    .readEnable(readEnable));
  initial begin
    clk = 0;
    forever #25 clk = ~clk;
  end
  task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] got);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask
  function automatic logic [8:0] nxt(input logic [8:0] c, input logic up);
    return up ? c + TAP_ONE : c - TAP_ONE;
  endfunction
  // MSB first behind two synchroniser stages: word bit 7-c carries pattern bit c-2
  function automatic logic [7:0] expWord(input logic [7:0] p);
    logic [7:0] r;
    r = '0;
    for (int c = 0; c < 8; c++) begin
      r[7-c] = p[(c+6)%8];
    end
    return r;
  endfunction
  // Serial pattern repeats every word, locked to the frame count from reset release
  always @(posedge clk) edgeNum <= sys_rst ? 0 : edgeNum + 1;
  always @(negedge clk) serialDataPin = pat[edgeNum[2:0]];
  // Value settles a cycle before the strobe; steps stay low throughout
  task automatic load(input logic [8:0] val);
    tapValueIn = val;
    cyc(1);
    tapLoad = 1;
    cyc(1);
    tapLoad = 0;
    cyc(1);
  endtask
  task automatic step(input logic up);
    ctrlStepInc = up;
    ctrlStepDec = !up;
    cyc(1);
    {ctrlStepInc, ctrlStepDec} = 2'h0;
    cyc(1);
  endtask
  task automatic window;
    {v, e, w} = '0;
    repeat (64) begin
      cyc(1);
      v += int'(readValid === 1'b1);
      e += int'(queueEmpty === 1'b1);
      w += int'(queueWriteClockOut === 1'b1);
    end
  endtask
  always @(negedge clk) begin
    if (dataOn && readValid === 1'b1)
      chk("readData", {1'b0, expWord(pat)}, {1'b0, readData});
  end
  initial begin
    cyc(3000);
    err_count++;
    complete_run();
  end
  initial begin
    pat = {4'h9, 4'($random(seed))};
    {driftCompEnable, tapLoad, isStrobeSlice, ctrlStepInc, ctrlStepDec, stall, dataOn} = '0;
    {isNibbleBase, sys_rst} = 2'h3;
    tapValueIn = TAP_RESET;
    cyc(20);
    sys_rst = 0;
    cyc(1);
    chk("tap reset", TAP_RESET, tapValueOut);
    cur = TAP_RESET;
    repeat (6) begin
      cur = cur + 9'($random(seed) & 7) + TAP_ONE;
      load(cur);
      chk("tap load", cur, tapValueOut);
    end
    isStrobeSlice = 1;
    load(cur + 9'h004);
    chk("strobe load", cur, tapValueOut);
    isStrobeSlice = 0;
    // Walk down to tap zero in legal moves of at most eight taps
    while (cur != TAP_RESET) begin
      cur = (cur > 9'h008) ? cur - 9'h008 : TAP_RESET;
      load(cur);
      chk("tap down", cur, tapValueOut);
    end
    step(1);
    chk("step off", TAP_RESET, tapValueOut);
    driftCompEnable = 1;
    cyc(3);
    chk("comp on", 9'h001, {8'h00, driftCompActive});
    step(0);
    chk("wrap down", nxt(TAP_RESET, 1'b0), tapValueOut);
    step(1);
    chk("wrap up", nxt(9'h1ff, 1'b1), tapValueOut);
    step(1);
    chk("step up", nxt(TAP_RESET, 1'b1), tapValueOut);
    step(0);
    chk("step down", TAP_RESET, tapValueOut);
    driftCompEnable = 0;
    stall = 1;
    // A read registered before the stall may still land
    cyc(2);
    window();
    chk("stalled reads", 9'h000, 9'(v));
    chk("full", 9'h000, {8'h00, captureReady});
    chk("overflow", 9'h001, {8'h00, captureOverflow});
    chk("not empty", 9'h000, {8'h00, queueEmpty});
    stall = 0;
    dataOn = 1;
    cyc(30);
    window();
    chk("word rate", 9'h008, 9'(v));
    chk("empty seen", 9'h001, 9'(e > 0));
    chk("write clock", 9'h020, 9'(w));
    isNibbleBase = 0;
    window();
    chk("empty off", 9'h000, 9'(e));
    complete_run();
  end
endmodule

// ### verilog/rx_slice_tap_fifo.sv
`timescale 1ns/100ps
module rx_slice_tap_fifo (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic serialDataPin,
  input wire logic driftCompEnable,
  input wire logic [rx_slice_pkg::TAP_WIDTH-1:0] tapValueIn,
  input wire logic tapLoad,
  input wire logic isStrobeSlice,
  input wire logic isNibbleBase,
  input wire logic ctrlStepInc,
  input wire logic ctrlStepDec,
  input wire logic readEnable,
  output logic [rx_slice_pkg::TAP_WIDTH-1:0] tapValueOut,
  output logic driftCompActive,
  output logic [rx_slice_pkg::WORD_WIDTH-1:0] readData,
  output logic readValid,
  output logic queueEmpty,
  output logic captureReady,
  output logic captureOverflow,
  output logic queueWriteClockOut
);
  import rx_slice_pkg::*;

  // Pin synchronisers; the first stage feeds only the second
  logic serialMeta_q, serialSync_q, compMeta_q, compSync_q;
  logic serialMeta_d, serialSync_d, compMeta_d, compSync_d;

  always_comb begin
    serialMeta_d = serialDataPin;
    serialSync_d = serialMeta_q;
    compMeta_d = driftCompEnable;
    compSync_d = compMeta_q;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      serialMeta_q <= 1'b0;
      serialSync_q <= 1'b0;
      compMeta_q <= 1'b0;
      compSync_q <= 1'b0;
    end else begin
      serialMeta_q <= serialMeta_d;
      serialSync_q <= serialSync_d;
      compMeta_q <= compMeta_d;
      compSync_q <= compSync_d;
    end
  end

  // Delay-line tap setting
  logic [TAP_WIDTH-1:0] tap_q, tap_d;
  logic loadAccepted;

  always_comb begin
    loadAccepted = tapLoad && !isStrobeSlice;
    tap_d = tap_q;
    if (loadAccepted) begin
      tap_d = tapValueIn;
    end else if (compSync_q && (ctrlStepInc != ctrlStepDec)) begin
      // Natural 9-bit overflow gives the required wrap
      if (ctrlStepInc) begin
        tap_d = tap_q + TAP_ONE;
      end else begin
        tap_d = tap_q - TAP_ONE;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tap_q <= TAP_RESET;
    end else begin
      tap_q <= tap_d;
    end
  end

  assign tapValueOut = tap_q;
  assign driftCompActive = compSync_q;

  // Deserialiser and divided write clock
  logic [BIT_COUNT_WIDTH-1:0] bitCount_q, bitCount_d;
  logic [WORD_WIDTH-1:0] shift_q, shift_d;
  logic wrClk_q, wrClk_d;
  logic writePulse;

  always_comb begin
    bitCount_d = bitCount_q + 3'h1;
    shift_d = {shift_q[WORD_WIDTH-2:0], serialSync_q};
    writePulse = (bitCount_q == BIT_COUNT_LAST);
    wrClk_d = wrClk_q;
    if (bitCount_q == BIT_COUNT_HALF) begin
      wrClk_d = 1'b1;
    end else if (writePulse) begin
      wrClk_d = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bitCount_q <= BIT_COUNT_RESET;
      shift_q <= WORD_RESET;
      wrClk_q <= 1'b0;
    end else begin
      bitCount_q <= bitCount_d;
      shift_q <= shift_d;
      wrClk_q <= wrClk_d;
    end
  end

  assign queueWriteClockOut = wrClk_q;

  // Two-entry word queue; pointer wrap bit tells full from empty
  logic [PTR_WIDTH-1:0] wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
  logic [WORD_WIDTH-1:0] mem_q [QUEUE_DEPTH];
  logic [WORD_WIDTH-1:0] readData_q, readData_d;
  logic readValid_q, readValid_d, overflow_q, overflow_d;
  logic ptrsEqual, full, push, pop;

  always_comb begin
    ptrsEqual = (wrPtr_q == rdPtr_q);
    full = (wrPtr_q[1] != rdPtr_q[1]) && (wrPtr_q[0] == rdPtr_q[0]);
    push = writePulse && !full;
    pop = readEnable && !ptrsEqual;
    wrPtr_d = push ? wrPtr_q + 2'h1 : wrPtr_q;
    rdPtr_d = pop ? rdPtr_q + 2'h1 : rdPtr_q;
    readData_d = pop ? mem_q[rdPtr_q[0]] : readData_q;
    readValid_d = pop;
    // A word arriving while full is lost; sticky so software notices
    overflow_d = overflow_q || (writePulse && full);
  end

  for (genvar e = 0; e < QUEUE_DEPTH; e++) begin : gEntry
    logic [WORD_WIDTH-1:0] entry_d;
    always_comb begin
      entry_d = (push && (wrPtr_q[0] == 1'(e))) ? shift_d : mem_q[e];
    end
    always_ff @(posedge clk) begin
      if (sys_rst) begin
        mem_q[e] <= WORD_RESET;
      end else begin
        mem_q[e] <= entry_d;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wrPtr_q <= PTR_RESET;
      rdPtr_q <= PTR_RESET;
      readData_q <= WORD_RESET;
      readValid_q <= 1'b0;
      overflow_q <= 1'b0;
    end else begin
      wrPtr_q <= wrPtr_d;
      rdPtr_q <= rdPtr_d;
      readData_q <= readData_d;
      readValid_q <= readValid_d;
      overflow_q <= overflow_d;
    end
  end

  assign readData = readData_q;
  assign readValid = readValid_q;
  assign queueEmpty = isNibbleBase && ptrsEqual;
  assign captureReady = !full;
  assign captureOverflow = overflow_q;

  a_load_takes_value: assert property (@(posedge clk) disable iff (sys_rst)
    (tapLoad && !isStrobeSlice) |=> tapValueOut == $past(tapValueIn))
    else $error("tap load not applied");

  a_strobe_load_ignored: assert property (@(posedge clk) disable iff (sys_rst)
    (tapLoad && isStrobeSlice && !compSync_q) |=> $stable(tapValueOut))
    else $error("tap load on strobe slice changed delay");

  a_comp_off_hold: assert property (@(posedge clk) disable iff (sys_rst)
    (!compSync_q && !tapLoad) |=> $stable(tapValueOut))
    else $error("delay changed with compensation off");

  a_comp_step_inc: assert property (@(posedge clk) disable iff (sys_rst)
    (compSync_q && ctrlStepInc && !ctrlStepDec && !tapLoad && tapValueOut != 9'h1ff)
    |=> tapValueOut == $past(tapValueOut) + 9'h001)
    else $error("compensation step not applied");

  a_tap_wrap_up: assert property (@(posedge clk) disable iff (sys_rst)
    (compSync_q && ctrlStepInc && !ctrlStepDec && !tapLoad && tapValueOut == 9'h1ff)
    |=> tapValueOut == 9'h000)
    else $error("tap did not wrap to zero");

  a_tap_wrap_down: assert property (@(posedge clk) disable iff (sys_rst)
    (compSync_q && ctrlStepDec && !ctrlStepInc && !tapLoad && tapValueOut == 9'h000)
    |=> tapValueOut == 9'h1ff)
    else $error("tap did not wrap to 511");

  a_read_hold: assert property (@(posedge clk) disable iff (sys_rst)
    !readEnable |=> $stable(rdPtr_q) && $stable(readData) && !readValid)
    else $error("read pointer moved without read enable");

  a_word_cadence: assert property (@(posedge clk) disable iff (sys_rst)
    writePulse |=> !writePulse [*7] ##1 writePulse)
    else $error("word cadence not eight cycles");

  a_wrclk_period: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(queueWriteClockOut) |-> ##4 $fell(queueWriteClockOut) ##4 $rose(queueWriteClockOut))
    else $error("write clock not divide by eight");

  a_push_clears_empty: assert property (@(posedge clk) disable iff (sys_rst)
    (push && isNibbleBase) |=> !queueEmpty)
    else $error("empty still high after a write");

  a_side_empty_low: assert property (@(posedge clk) disable iff (sys_rst)
    !isNibbleBase |-> !queueEmpty)
    else $error("empty driven on non-base slice");

  a_pop_only_written: assert property (@(posedge clk) disable iff (sys_rst)
    (readEnable && ptrsEqual) |=> !readValid && $stable(readData))
    else $error("read from empty queue");

  // Two-stage lag; skipped until both stages have left reset
  a_comp_sync_lag: assert property (@(posedge clk) disable iff (sys_rst)
    (!$past(sys_rst) && !$past(sys_rst, 2))
    |-> driftCompActive == $past(driftCompEnable, 2))
    else $error("compensation enable not two stages late");

  a_comp_step_dec: assert property (@(posedge clk) disable iff (sys_rst)
    (compSync_q && ctrlStepDec && !ctrlStepInc && !tapLoad && tapValueOut != 9'h000)
    |=> tapValueOut == $past(tapValueOut) - 9'h001)
    else $error("compensation step down not applied");

  a_comp_off_steps: assert property (@(posedge clk) disable iff (sys_rst)
    (!compSync_q && !tapLoad && (ctrlStepInc || ctrlStepDec)) |=> $stable(tapValueOut))
    else $error("controller step applied with compensation off");

  a_tap_out_steady: assert property (@(posedge clk) disable iff (sys_rst)
    (!tapLoad && !(compSync_q && (ctrlStepInc != ctrlStepDec))) |=> $stable(tapValueOut))
    else $error("tap output moved without load or step");

  a_pop_advances: assert property (@(posedge clk) disable iff (sys_rst)
    (readEnable && !ptrsEqual) |=> readValid && (rdPtr_q == $past(rdPtr_q) + 2'h1))
    else $error("read with data did not advance");

  a_valid_from_read: assert property (@(posedge clk) disable iff (sys_rst)
    readValid |-> $past(readEnable))
    else $error("read valid without read enable");

  a_last_pop_empty: assert property (@(posedge clk) disable iff (sys_rst)
    (pop && !push && (rdPtr_q + 2'h1 == wrPtr_q)) |=> queueEmpty == isNibbleBase)
    else $error("empty not raised after last word");

  a_empty_no_valid: assert property (@(posedge clk) disable iff (sys_rst)
    queueEmpty |=> !readValid)
    else $error("read data from an empty queue");

  a_write_at_high: assert property (@(posedge clk) disable iff (sys_rst)
    writePulse |-> queueWriteClockOut ##1 !queueWriteClockOut)
    else $error("write not at end of clock high phase");

  // A difference of three would mean a pointer skipped past the reader
  a_queue_bounded: assert property (@(posedge clk) disable iff (sys_rst)
    (wrPtr_q - rdPtr_q) <= 2'h2)
    else $error("queue holds more than two words");

  a_room_when_empty: assert property (@(posedge clk) disable iff (sys_rst)
    ptrsEqual |-> captureReady)
    else $error("ready low with empty queue");

  a_ready_after_pop: assert property (@(posedge clk) disable iff (sys_rst)
    (!captureReady && readEnable) |=> captureReady)
    else $error("queue still full after a read");

  a_overflow_set: assert property (@(posedge clk) disable iff (sys_rst)
    (writePulse && !captureReady) |=> captureOverflow)
    else $error("dropped word not flagged");

  a_overflow_sticky: assert property (@(posedge clk) disable iff (sys_rst)
    captureOverflow |=> captureOverflow)
    else $error("overflow flag cleared without reset");

endmodule
